// ==== tb/hif_host.sv ====
// host-side model that issues feature commands and fabric connects
`timescale 1ns/1ps
module hif_host (
    // clock
    input wire logic clk,
    // command request
    output logic cmd_valid,
    output logic cmd_is_set,
    output logic [7:0] cmd_fid,
    output logic [31:0] cmd_dw11,
    // set payload
    output logic in_valid,
    output logic [7:0] in_byte,
    // fabric connect
    output logic connect_valid,
    output logic [127:0] connect_id
);
    // quiet lines from time zero
    initial begin
        {cmd_valid, in_valid, connect_valid} = 3'h0;
        {cmd_is_set, cmd_fid, cmd_dw11, in_byte, connect_id} = '0;
    end

    // one command, then 8 or 16 payload bytes for a set
    task automatic issue(input logic set, input logic [7:0] fid,
                         input logic wide, input logic [127:0] id);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_is_set = set;
        cmd_fid = fid;
        cmd_dw11 = {31'h0, wide}; // reserved bits kept zero
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_is_set = ~set;
        cmd_fid = ~fid;
        cmd_dw11 = ~cmd_dw11;
        // byte k carries bits 8k+7:8k
        for (int k = 0; set && k < (wide ? 16 : 8); k++) begin
            in_valid = 1'b1;
            in_byte = id[8*k +: 8];
            @(negedge clk);
        end
        in_valid = 1'b0;
        in_byte = ~in_byte; // released line must not show a stale byte
    endtask

    // connect carries the identifier the caller chose, nonzero
    task automatic connect(input logic [127:0] id);
        @(negedge clk);
        connect_valid = 1'b1;
        connect_id = id;
        @(negedge clk);
        connect_valid = 1'b0;
        connect_id = ~id;
    endtask
endmodule

// ==== tb/test_host_identifier_feature.sv ====
// self-checking bench for the host identifier feature block
`timescale 1ns/1ps
module test_host_identifier_feature;
    import hif_pkg::*;
    // clock, reset and shared command lines
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid, cmd_is_set, in_valid, connect_valid;
    logic [7:0] cmd_fid, in_byte;
    logic [31:0] cmd_dw11;
    logic [127:0] connect_id;
    logic peer_nz = 1'b0;
    logic peer_w = 1'b0;
    logic [127:0] peer_id = '0;
    // outputs per configuration: 0 plain, 1 fabric, 2 no 64, 3 no 128
    logic [3:0] cpl_valid, out_valid, wide_sel, same_host, drop_res;
    logic [2:0] cpl_sct [4];
    logic [7:0] cpl_sc [4];
    logic [7:0] out_byte [4];
    logic [127:0] id_q [4];
    // bench bookkeeping
    logic [127:0] exp_id [4];
    logic [127:0] got_id [4];
    logic [3:0] cpl_cnt [4];
    logic [4:0] nbyte [4];
    logic exp_wide [4];
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 55192;

    // 10 MHz clock
    always #50 clk = ~clk;

    hif_host hif_host_inst (.clk(clk), .cmd_valid(cmd_valid),
        .cmd_is_set(cmd_is_set), .cmd_fid(cmd_fid), .cmd_dw11(cmd_dw11),
        .in_valid(in_valid), .in_byte(in_byte),
        .connect_valid(connect_valid), .connect_id(connect_id));

    // all four configurations see the same commands
    for (genvar g = 0; g < 4; g++) begin : cfg
        hif_feature #(.FABRIC(g == 1), .SUP64(g != 1 && g != 2),
            .SUP128(g != 3)) hif_feature_inst (.clk(clk), .reset(reset),
            .cmd_valid(cmd_valid), .cmd_is_set(cmd_is_set),
            .cmd_fid(cmd_fid), .cmd_dw11(cmd_dw11), .in_valid(in_valid),
            .in_byte(in_byte), .connect_valid(connect_valid),
            .connect_id(connect_id), .peer_id_nonzero(peer_nz),
            .peer_wide(peer_w), .peer_id(peer_id),
            .cpl_valid(cpl_valid[g]), .cpl_sct(cpl_sct[g]),
            .cpl_sc(cpl_sc[g]), .out_valid(out_valid[g]),
            .out_byte(out_byte[g]), .host_identity_value(id_q[g]),
            .wide_id_select(wide_sel[g]), .same_host_as_peer(same_host[g]),
            .drop_reservations(drop_res[g]));
    end

    // gather completions and get data; also bound a hung run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        for (int g = 0; g < 4; g++) begin
            if (cpl_valid[g] === 1'b1)
                cpl_cnt[g] <= cpl_cnt[g] + 4'h1;
            if (out_valid[g] === 1'b1) begin
                got_id[g][8*nbyte[g] +: 8] <= out_byte[g];
                nbyte[g] <= nbyte[g] + 5'h1;
            end
        end
        if (cycles == 5000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    function automatic logic [127:0] rnd();
        return {$random(seed), $random(seed), $random(seed), $random(seed)};
    endfunction

    // expected status word {sct, sc} per configuration
    function automatic logic [10:0] exp_st(int g, logic set, logic wide);
        if (set && g == 1)
            return {HIF_SCT_GEN, HIF_SC_CMD_SEQ};
        if (set && ((g == 2 && !wide) || (g == 3 && wide)))
            return {HIF_SCT_GEN, HIF_SC_INV_FIELD};
        if (set && g == 0 && peer_nz && peer_w != wide)
            return {HIF_SCT_CMD, HIF_SC_INCONS};
        return {HIF_SCT_GEN, HIF_SC_OK};
    endfunction

    // one command to every configuration, then judge each answer
    task automatic run(input logic [7:0] fid, input logic set,
                       input logic wide, input logic [127:0] id);
        logic [10:0] e;
        for (int g = 0; g < 4; g++) begin
            cpl_cnt[g] = '0;
            nbyte[g] = '0;
        end
        hif_host_inst.issue(set, fid, wide, id);
        repeat (20) @(negedge clk);
        for (int g = 0; g < 4; g++) begin
            e = exp_st(g, set, wide);
            if (fid !== HIF_FID) begin
                check(cpl_cnt[g], 0);
                continue;
            end
            check(cpl_cnt[g], 1);
            check({cpl_sct[g], cpl_sc[g]}, e);
            if (!set)
                check(got_id[g], exp_id[g]);
            if (set && e == {HIF_SCT_GEN, HIF_SC_OK}) begin
                exp_id[g] = wide ? id : {64'h0, id[63:0]};
                exp_wide[g] = wide;
                check(id_q[g], exp_id[g]);
                check(wide_sel[g], exp_wide[g]);
            end
        end
        check(same_host[0], exp_id[0] != 0 && exp_id[0] == peer_id &&
            exp_wide[0] == peer_w && peer_nz);
    endtask

    // main sequence: corners first, then random traffic, then a reset
    initial begin
        logic [127:0] r;
        logic s, w;
        for (int g = 0; g < 4; g++) begin
            {exp_id[g], got_id[g], cpl_cnt[g], nbyte[g], exp_wide[g]} = '0;
        end
        repeat (8) @(posedge clk);
        check(drop_res, 4'hf);
        @(negedge clk);
        reset = 1'b0;
        r = rnd() | 128'h1;
        hif_host_inst.connect(r);
        exp_id[1] = r;
        run(HIF_FID, 1'b1, 1'b1, rnd());
        check(drop_res, 4'h0);
        check(wide_sel[1], 1'b1);
        run(HIF_FID, 1'b1, 1'b0, rnd());
        run(8'h80, 1'b1, 1'b1, rnd());
        run(HIF_FID, 1'b1, 1'b1, '0);
        for (int i = 0; i < 16; i++) begin
            r = ($random(seed) & 3) == 0 ? '1 : rnd();
            s = 1'($random(seed));
            w = 1'($random(seed));
            peer_w = 1'($random(seed));
            peer_id = ($random(seed) & 1) ? (peer_w ? r : {64'h0, r[63:0]})
                : rnd();
            peer_nz = peer_id != 0;
            run(HIF_FID, s, w, r);
        end
        reset = 1'b1;
        @(negedge clk);
        check(drop_res, 4'hf);
        check(id_q[0], 0);
        test_done();
    end
endmodule

// ==== verilog/hif_feature.sv ====
// host identifier feature command interpreter
`timescale 1ns/1ps
module hif_feature
    import hif_pkg::*;
#(
    parameter bit FABRIC = 1'b0,
    parameter bit SUP64 = 1'b1,
    parameter bit SUP128 = 1'b1
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // command request
    input wire logic cmd_valid,
    input wire logic cmd_is_set,
    input wire logic [7:0] cmd_fid,
    input wire logic [31:0] cmd_dw11,
    // set-feature payload bytes, one per cycle
    input wire logic in_valid,
    input wire logic [7:0] in_byte,
    // fabric connect capture
    input wire logic connect_valid,
    input wire logic [127:0] connect_id,
    // peer controller state
    input wire logic peer_id_nonzero,
    input wire logic peer_wide,
    input wire logic [127:0] peer_id,
    // completion
    output logic cpl_valid,
    output logic [2:0] cpl_sct,
    output logic [7:0] cpl_sc,
    // get-feature data buffer
    output logic out_valid,
    output logic [7:0] out_byte,
    // identity state
    output logic [127:0] host_identity_value,
    output logic wide_id_select,
    output logic same_host_as_peer,
    output logic drop_reservations
);
    // sequencer state and byte walk
    hif_state_e state_q;
    logic [3:0] cnt_q; // byte index
    logic [3:0] last_q; // final byte index for this transfer
    // set payload staging, kept apart so a cut set never reaches id_q
    logic [127:0] shadow_q; // incoming identifier
    logic wide_q; // requested width
    // live identifier and its width
    logic [127:0] id_q; // identifier in force
    logic idw_q; // width in force, 1 for 128-bit
    logic same_d; // comparator result, registered below
    // command decode
    logic hit; // command targets this feature
    logic req_wide; // width asked for by the command
    logic bad128; // wide asked, not supported
    logic bad64; // narrow asked, not supported
    logic incons; // clashes with a peer's width

    // other feature ids pass by untouched
    assign hit = cmd_valid && (cmd_fid == HIF_FID); // [RL1]
    // reserved bits are not checked, so odd hosts still get through
    assign req_wide = cmd_dw11[HIF_WSEL_BIT]; // [RL3] upper bits ignored
    // width support is fixed at build time
    assign bad128 = req_wide && !SUP128; // [RL5]
    // fabric parts never run narrow
    assign bad64 = !req_wide && (!SUP64 || FABRIC); // [RL6] [RL4]
    // only a part that offers both widths can see a clash
    assign incons = SUP64 && SUP128 && peer_id_nonzero &&
                    (peer_wide != req_wide); // [RL7]

    // command sequencing
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= HIF_IDLE;
            cnt_q <= 4'h0;
            last_q <= 4'h0;
            wide_q <= 1'b0;
            cpl_valid <= 1'b0;
            cpl_sct <= HIF_SCT_GEN;
            cpl_sc <= HIF_SC_OK;
            out_valid <= 1'b0;
            out_byte <= 8'h00;
        end else begin
            cpl_valid <= 1'b0;
            out_valid <= 1'b0;
            unique case (state_q)
                HIF_IDLE: begin
                    cnt_q <= 4'h0;
                    if (hit && cmd_is_set) begin
                        if (FABRIC) begin
                            // identifier fixed by connect
                            cpl_valid <= 1'b1; // [RL15]
                            cpl_sct <= HIF_SCT_GEN;
                            cpl_sc <= HIF_SC_CMD_SEQ;
                        end else if (bad128 || bad64) begin
                            cpl_valid <= 1'b1; // [RL5] [RL6]
                            cpl_sct <= HIF_SCT_GEN;
                            cpl_sc <= HIF_SC_INV_FIELD;
                        end else if (incons) begin
                            cpl_valid <= 1'b1; // [RL7]
                            cpl_sct <= HIF_SCT_CMD;
                            cpl_sc <= HIF_SC_INCONS;
                        end else begin
                            wide_q <= req_wide;
                            last_q <= req_wide ? HIF_LAST_BYTE
                                               : HIF_LAST_LOW; // [RL8]
                            state_q <= HIF_RECV;
                        end
                    end else if (hit) begin
                        // get always ships the full 16-byte structure
                        last_q <= HIF_LAST_BYTE; // [RL2] [RL8]
                        state_q <= HIF_SEND;
                    end
                end
                HIF_RECV: begin
                    if (in_valid) begin
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == last_q) begin
                            state_q <= HIF_APPLY;
                        end
                    end
                end
                HIF_APPLY: begin
                    // id registers load this cycle; complete next
                    state_q <= HIF_DONE; // [RL17]
                end
                HIF_SEND: begin
                    out_valid <= 1'b1; // [RL2] data, not completion
                    out_byte <= id_q[cnt_q*8 +: 8]; // [RL16] [RL18]
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == last_q) begin
                        state_q <= HIF_DONE;
                    end
                end
                HIF_DONE: begin
                    cpl_valid <= 1'b1; // [RL17]
                    cpl_sct <= HIF_SCT_GEN;
                    cpl_sc <= HIF_SC_OK;
                    state_q <= HIF_IDLE;
                end
                default: state_q <= HIF_IDLE;
            endcase
        end
    end

    // payload capture, little endian byte order
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            shadow_q <= HIF_ZERO_ID;
        end else if (state_q == HIF_IDLE) begin
            shadow_q <= HIF_ZERO_ID; // [RL18] upper bytes stay zero
        end else if (state_q == HIF_RECV && in_valid) begin
            shadow_q[cnt_q*8 +: 8] <= in_byte; // [RL8]
        end
    end

    // stored identifier; reset forgets it, so zero is a new host
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            id_q <= HIF_ZERO_ID;
            idw_q <= 1'b0;
        end else if (FABRIC && connect_valid) begin
            id_q <= connect_id; // [RL16] [RL14]
            idw_q <= 1'b1; // [RL4]
        end else if (!FABRIC && state_q == HIF_APPLY) begin
            id_q <= shadow_q; // [RL12] remap at any time
            idw_q <= wide_q; // [RL13] width per SUP128
        end
    end

    hif_match hif_match_inst (
        .own_id(id_q),
        .own_wide(idw_q),
        .peer_id(peer_id),
        .peer_wide(peer_wide),
        .same_host(same_d)
    );

    // registered outputs
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            host_identity_value <= HIF_ZERO_ID;
            wide_id_select <= 1'b0;
            same_host_as_peer <= 1'b0;
            drop_reservations <= 1'b1; // [RL11] zero id after reset
        end else begin
            host_identity_value <= id_q;
            wide_id_select <= idw_q;
            same_host_as_peer <= same_d; // [RL9] [RL10]
            drop_reservations <= 1'b0;
        end
    end

    // checks on the sequencer and the stored identity

    // fabric: any set is refused, the id is fixed by connect
    AST_FABRIC_SET_SEQ: assert property (@(posedge clk) // [RL15]
        disable iff (reset)
        (FABRIC && state_q == HIF_IDLE && hit && cmd_is_set) |=>
        (cpl_valid && cpl_sc == HIF_SC_CMD_SEQ))
        else $error("fabric set not aborted");

    // unsupported width is answered at once, nothing stored
    AST_BAD_WIDTH: assert property (@(posedge clk) // [RL5] [RL6]
        disable iff (reset)
        (!FABRIC && state_q == HIF_IDLE && hit && cmd_is_set &&
         (bad128 || bad64)) |=>
        (cpl_valid && cpl_sc == HIF_SC_INV_FIELD))
        else $error("unsupported width not rejected");

    // width clash with a peer is command specific status
    AST_INCONS: assert property (@(posedge clk) // [RL7]
        disable iff (reset)
        (!FABRIC && state_q == HIF_IDLE && hit && cmd_is_set &&
         !bad128 && !bad64 && incons) |=>
        (cpl_valid && cpl_sc == HIF_SC_INCONS))
        else $error("inconsistent format not flagged");

    // new id must be in force before the good completion
    AST_APPLY_BEFORE_CPL: assert property (@(posedge clk) // [RL17]
        disable iff (reset)
        (state_q == HIF_APPLY) |=> (id_q == $past(shadow_q)) ##1
        (cpl_valid && cpl_sc == HIF_SC_OK))
        else $error("completion before apply");

    // narrow mode keeps the upper half clear
    AST_LOW_ONLY: assert property (@(posedge clk) // [RL18]
        disable iff (reset)
        (!idw_q && !FABRIC) |->
        (id_q[127:64] == 64'h0))
        else $error("upper bytes kept in 64-bit mode");

    // get answers with data first, never with the completion alone
    AST_GET_DATA: assert property (@(posedge clk) // [RL2]
        disable iff (reset)
        (state_q == HIF_IDLE && hit && !cmd_is_set) |=>
        !cpl_valid ##1 out_valid)
        else $error("get did not use data buffer");

    // a zero identifier never joins another controller
    AST_ZERO_APART: assert property (@(posedge clk) // [RL10]
        disable iff (reset)
        (id_q == HIF_ZERO_ID) |=>
        !same_host_as_peer)
        else $error("zero identifiers matched");

    // connect value lands whole and wide
    AST_FABRIC_WIDE: assert property (@(posedge clk) // [RL16]
        disable iff (reset)
        (FABRIC && $past(connect_valid)) |->
        (idw_q && id_q == $past(connect_id)))
        else $error("connect identifier not captured");

    // other feature ids get no answer from this block
    AST_IGNORE_OTHER: assert property (@(posedge clk) // [RL1]
        disable iff (reset)
        (state_q == HIF_IDLE && !hit) |=>
        (!cpl_valid && !out_valid && state_q == HIF_IDLE))
        else $error("foreign feature id answered");

    // wide id can only be in force where wide is offered
    AST_WIDE_SUP: assert property (@(posedge clk) // [RL13]
        disable iff (reset)
        (!FABRIC && idw_q) |->
        SUP128)
        else $error("wide id stored without support");

    // a stored narrow id needs narrow support
    AST_NARROW_SUP: assert property (@(posedge clk) // [RL6]
        disable iff (reset)
        (!FABRIC && !idw_q && id_q != HIF_ZERO_ID) |->
        SUP64)
        else $error("narrow id stored without support");

    // fabric id moves only on a connect
    AST_FABRIC_FIXED: assert property (@(posedge clk) // [RL16]
        disable iff (reset)
        (FABRIC && !connect_valid) |=>
        $stable(id_q))
        else $error("fabric identifier modified");

    // data strobe and completion never share a cycle
    AST_DATA_NOT_CPL: assert property (@(posedge clk) // [RL2]
        disable iff (reset)
        out_valid |->
        !cpl_valid)
        else $error("data and completion overlap");

    // the done state always posts one good completion
    AST_DONE_OK: assert property (@(posedge clk) // [RL17]
        disable iff (reset)
        (state_q == HIF_DONE) |=>
        (cpl_valid && cpl_sct == HIF_SCT_GEN && cpl_sc == HIF_SC_OK))
        else $error("done without good completion");

    // same host needs an equal nonzero id one cycle back
    AST_SAME_EQUAL: assert property (@(posedge clk) // [RL9]
        disable iff (reset)
        same_host_as_peer |->
        ($past(id_q) == $past(peer_id) && $past(id_q) != HIF_ZERO_ID))
        else $error("same host without equal id");

    // last payload byte moves straight to apply
    AST_RECV_LAST: assert property (@(posedge clk) // [RL8]
        disable iff (reset)
        (state_q == HIF_RECV && in_valid && cnt_q == last_q) |=>
        (state_q == HIF_APPLY))
        else $error("payload length wrong");

    // last data byte is shipped, then the completion follows
    AST_SEND_LAST: assert property (@(posedge clk) // [RL8]
        disable iff (reset)
        (state_q == HIF_SEND && cnt_q == last_q) |=>
        (out_valid && state_q == HIF_DONE))
        else $error("get length wrong");
endmodule

// ==== verilog/hif_match.sv ====
// host association comparator for one peer controller
`timescale 1ns/1ps
module hif_match
    import hif_pkg::*;
(
    // own identifier
    input wire logic [127:0] own_id,
    input wire logic own_wide,
    // peer identifier
    input wire logic [127:0] peer_id,
    input wire logic peer_wide,
    // result
    output logic same_host
);
    // zero never matches anything, even another zero
    assign same_host = (own_id != HIF_ZERO_ID) && // [RL9] [RL10]
                       (own_id == peer_id) && (own_wide == peer_wide);
endmodule

// ==== verilog/hif_pkg.sv ====
// constants shared by the host identifier feature block
// What this block does
// [RL1] feature id 81h selects host identifier
// [RL2] get-feature returns identifier via data buffer
// [RL3] dword11 bit 0 selects 128 or 64 bit
// [RL4] fabric controllers always use 128-bit format
// [RL5] no 128-bit support and bit one: invalid field
// [RL6] no 64-bit support and bit zero: invalid field
// [RL7] other controller other width nonzero: inconsistent format; checked only when both SUP64 and SUP128 are set
// [RL8] identifier is bytes 15:00, 8 or 16 sent
// [RL9] equal nonzero identifiers mean same host
// [RL10] zero identifiers always mean different hosts
// [RL11] zero identifier reservations dropped on reset
// [RL12] memory-bus controllers may change identifier anytime
// [RL13] 128-bit support recommended on memory-bus controllers
// [RL14] host gives nonzero identifier in fabric connect
// [RL15] fabric set-feature aborts with sequence error
// [RL16] fabric get-feature returns connect identifier
// [RL17] completion posted only after attributes applied
// [RL18] 64-bit mode stores low 8 bytes only
package hif_pkg;
    localparam logic [7:0] HIF_FID = 8'h81;
    localparam int HIF_WSEL_BIT = 0;
    localparam int HIF_BYTES = 16;
    localparam int HIF_LOW_BYTES = 8;
    localparam logic [3:0] HIF_LAST_BYTE = 4'hf;
    localparam logic [3:0] HIF_LAST_LOW = 4'h7;
    // status codes: generic type 0, command specific type 1
    localparam logic [2:0] HIF_SCT_GEN = 3'h0;
    localparam logic [2:0] HIF_SCT_CMD = 3'h1;
    localparam logic [7:0] HIF_SC_OK = 8'h00;
    localparam logic [7:0] HIF_SC_INV_FIELD = 8'h02;
    localparam logic [7:0] HIF_SC_CMD_SEQ = 8'h0c;
    localparam logic [7:0] HIF_SC_INCONS = 8'h19;
    localparam logic [127:0] HIF_ZERO_ID = 128'h0;
    typedef enum logic [2:0] {
        HIF_IDLE = 3'b000,
        HIF_RECV = 3'b001,
        HIF_APPLY = 3'b010,
        HIF_SEND = 3'b011,
        HIF_DONE = 3'b100
    } hif_state_e;
endpackage
